// file: sms_port.sv
// spi master/slave port with configuration registers and byte fifos
// Notes on behaviour
// RULE_01 - reading the receive holding register pops one byte from the receive fifo and returns it.
// RULE_02 - each complete byte shifted in from the bus is pushed into the receive fifo, unless the fifo is full with overrun replace 0.
// RULE_03 - irq source select 0 raises the interrupt on receive full, 1 on transmit empty.
// RULE_04 - master with auto select 0 holds slave select low continuously.
// RULE_05 - master with auto select 1 drives slave select low for a byte or a continuous burst, then high.
// RULE_06 - slave with select input enable 1 uses the select pin to qualify transfers.
// RULE_07 - overrun replace 0 drops a new byte while the receive fifo is full.
// RULE_08 - overrun replace 1 lets a new byte replace unread holding data.
// RULE_09 - master sclk is core clock divided by 8, 16, 32 or 64 per the rate field.
// RULE_10 - master without continuous transfer stops after each byte, deasserts select if auto select is 1, then stalls.
// RULE_11 - master with continuous transfer sends back to back while transmit data remains.
// RULE_12 - during continuous transfer select stays asserted until holding and shift registers are empty.
// RULE_13 - port enable 0, its reset value, keeps the port disabled with no transfers.
// RULE_14 - port enable 1 lets the port perform transfers.
// RULE_15 - master select 0 makes the port a slave, 1 a master.
// RULE_16 - writing the transmit holding register pushes the byte into the transmit fifo for sending.
// RULE_17 - all configuration is registered on the core clock and resets to its defaults.
`include "sms_map.svh"
module sms_port #(
   parameter int FIFO_DEPTH = 2,
   parameter int STALL_CYCLES = `SMS_STALL_CYC
)(
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic [7:0] i_addr,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_rdata,
   output logic o_irq,
   input wire logic i_sclk,
   input wire logic i_mosi,
   input wire logic i_miso,
   input wire logic i_ss_n,
   output sms_pkg::sms_pins_t o_pins
);
   if (STALL_CYCLES < 1)
   begin : g_stall_check
      $error("stall count must be at least one");
   end
   logic [7:0] cfg_one;
   logic [7:0] cfg_two;
   logic [2:0] sclk_sync;
   logic [1:0] mosi_sync;
   logic [1:0] miso_sync;
   logic [1:0] ss_sync;
   sms_pkg::sms_state_t state;
   logic [7:0] tx_shift;
   logic [7:0] rx_shift;
   logic [3:0] bit_cnt;
   logic [5:0] div_cnt;
   logic [7:0] stall_cnt;
   logic burst;
   logic [7:0] tx_q;
   logic tx_empty;
   logic tx_full;
   logic tx_pop;
   logic [7:0] rx_q;
   logic rx_empty;
   logic rx_full;
   logic rx_push;
   logic rx_pop;
   logic [7:0] rx_byte;
   logic byte_done;
   logic port_en;
   logic is_master;
   logic slave_sel;
   logic slave_rise;
   logic slave_fall;
   logic [5:0] half_div;

   function automatic logic sms_hit(input logic [7:0] a, input logic [7:0] reg_addr);
      sms_hit = (a == reg_addr);
   endfunction

   assign port_en = cfg_two[`SMS_BIT_PORT_EN];
   assign is_master = cfg_two[`SMS_BIT_MASTER]; // RULE_15
   // RULE_09
   assign half_div = 6'h04 << cfg_one[1:0];

   // configuration registers
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         cfg_one <= `SMS_CFG1_RST; // RULE_17
         cfg_two <= `SMS_CFG2_RST;
      end
      else if (i_wr)
      begin
         if (sms_hit(i_addr, `SMS_ADDR_CFG1))
            cfg_one <= i_wdata & `SMS_CFG1_MASK;
         else if (sms_hit(i_addr, `SMS_ADDR_CFG2))
            cfg_two <= i_wdata & `SMS_CFG2_MASK;
      end
   end

   // read data
   assign rx_pop = i_rd && sms_hit(i_addr, `SMS_ADDR_RX); // RULE_01
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
         o_rdata <= `SMS_RX_RST;
      else if (i_rd)
      begin
         if (sms_hit(i_addr, `SMS_ADDR_RX))
            o_rdata <= rx_empty ? `SMS_RX_RST : rx_q; // RULE_01
         else if (sms_hit(i_addr, `SMS_ADDR_CFG1))
            o_rdata <= cfg_one;
         else if (sms_hit(i_addr, `SMS_ADDR_CFG2))
            o_rdata <= cfg_two;
         else
            o_rdata <= 8'h00;
      end
   end

   // pin synchronisers
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         sclk_sync <= 3'h0;
         mosi_sync <= 2'h0;
         miso_sync <= 2'h0;
         ss_sync <= 2'h3;
      end
      else
      begin
         sclk_sync <= {sclk_sync[1:0], i_sclk};
         mosi_sync <= {mosi_sync[0], i_mosi};
         miso_sync <= {miso_sync[0], i_miso};
         ss_sync <= {ss_sync[0], i_ss_n};
      end
   end

   // RULE_06
   assign slave_sel = !cfg_one[`SMS_BIT_SS_IN_EN] || !ss_sync[1];
   assign slave_rise = sclk_sync[1] && !sclk_sync[2];
   assign slave_fall = !sclk_sync[1] && sclk_sync[2];

   // transmit fifo
   sms_fifo #(
      .DEPTH(FIFO_DEPTH)
   ) u_tx_fifo (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_push(i_wr && sms_hit(i_addr, `SMS_ADDR_TX)), // RULE_16
      .i_data(i_wdata),
      .i_pop(tx_pop),
      .o_data(tx_q),
      .o_empty(tx_empty),
      .o_full(tx_full)
   );

   // receive fifo
   // RULE_07 RULE_08
   assign rx_push = byte_done && (!rx_full || cfg_one[`SMS_BIT_RX_REPLACE]);
   sms_fifo #(
      .DEPTH(FIFO_DEPTH)
   ) u_rx_fifo (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_push(rx_push), // RULE_02
      .i_data(rx_byte),
      .i_pop(rx_pop || (byte_done && rx_full && cfg_one[`SMS_BIT_RX_REPLACE])),
      .o_data(rx_q),
      .o_empty(rx_empty),
      .o_full(rx_full)
   );

   // transfer engine
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         state <= sms_pkg::SMS_IDLE;
         tx_shift <= 8'h00;
         rx_shift <= 8'h00;
         rx_byte <= 8'h00;
         bit_cnt <= 4'h0;
         div_cnt <= 6'h00;
         stall_cnt <= 8'h00;
         burst <= 1'b0;
         byte_done <= 1'b0;
         tx_pop <= 1'b0;
         o_pins <= '0;
         o_pins.ss <= 1'b1;
      end
      else
      begin
         byte_done <= 1'b0;
         tx_pop <= 1'b0;
         if (!port_en)
         begin
            state <= sms_pkg::SMS_IDLE; // RULE_13
            burst <= 1'b0;
            o_pins <= '0;
            o_pins.ss <= 1'b1;
         end
         else if (is_master)
         begin
            o_pins.mosi_oe <= 1'b1; // RULE_14
            o_pins.ss_oe <= 1'b1;
            o_pins.miso_oe <= 1'b0;
            if (!cfg_one[`SMS_BIT_AUTO_SS])
               o_pins.ss <= 1'b0; // RULE_04
            case (state)
               sms_pkg::SMS_IDLE:
               begin
                  o_pins.sclk <= 1'b0;
                  if (!tx_pop && !tx_empty)
                  begin
                     tx_shift <= tx_q;
                     tx_pop <= 1'b1;
                     o_pins.mosi <= tx_q[7];
                     bit_cnt <= 4'h0;
                     div_cnt <= 6'h00;
                     burst <= cfg_two[`SMS_BIT_CONT];
                     if (cfg_one[`SMS_BIT_AUTO_SS])
                        o_pins.ss <= 1'b0; // RULE_05
                     state <= sms_pkg::SMS_SHIFT;
                  end
                  else if (cfg_one[`SMS_BIT_AUTO_SS])
                     o_pins.ss <= 1'b1;
               end
               sms_pkg::SMS_SHIFT:
               begin
                  if (div_cnt == half_div - 6'h01)
                  begin
                     div_cnt <= 6'h00;
                     o_pins.sclk <= !o_pins.sclk;
                     if (!o_pins.sclk)
                        rx_shift <= {rx_shift[6:0], miso_sync[1]};
                     else
                     begin
                        tx_shift <= {tx_shift[6:0], 1'b0};
                        o_pins.mosi <= tx_shift[6];
                        bit_cnt <= bit_cnt + 4'h1;
                        if (bit_cnt == 4'h7)
                           state <= sms_pkg::SMS_DONE;
                     end
                  end
                  else
                     div_cnt <= div_cnt + 6'h01;
               end
               sms_pkg::SMS_DONE:
               begin
                  rx_byte <= rx_shift;
                  byte_done <= 1'b1;
                  // RULE_11 RULE_12
                  if (burst && cfg_two[`SMS_BIT_CONT] && !tx_empty)
                  begin
                     tx_shift <= tx_q;
                     tx_pop <= 1'b1;
                     o_pins.mosi <= tx_q[7];
                     bit_cnt <= 4'h0;
                     div_cnt <= 6'h00;
                     state <= sms_pkg::SMS_SHIFT;
                  end
                  else
                  begin
                     if (cfg_one[`SMS_BIT_AUTO_SS])
                        o_pins.ss <= 1'b1; // RULE_10
                     burst <= 1'b0;
                     bit_cnt <= 4'h0;
                     stall_cnt <= 8'h00;
                     state <= sms_pkg::SMS_STALL;
                  end
               end
               sms_pkg::SMS_STALL:
               begin
                  stall_cnt <= stall_cnt + 8'h01; // RULE_10
                  if (stall_cnt == 8'(STALL_CYCLES - 1))
                     state <= sms_pkg::SMS_IDLE;
               end
               default:
                  state <= sms_pkg::SMS_IDLE;
            endcase
         end
         else
         begin
            // slave: sample on rising, shift out on falling
            o_pins.mosi_oe <= 1'b0;
            o_pins.ss_oe <= 1'b0;
            o_pins.sclk <= 1'b0;
            o_pins.ss <= 1'b1;
            o_pins.miso_oe <= slave_sel;
            state <= sms_pkg::SMS_IDLE;
            if (!slave_sel)
               bit_cnt <= 4'h0;
            else if (slave_rise)
            begin
               rx_shift <= {rx_shift[6:0], mosi_sync[1]};
               if (bit_cnt == 4'h0 && !tx_pop)
               begin
                  // bit 7 is already on the pin, keep the rest
                  tx_shift <= tx_empty ? 8'h00 : {tx_q[6:0], 1'b0};
                  tx_pop <= !tx_empty;
               end
               bit_cnt <= bit_cnt + 4'h1;
               if (bit_cnt == 4'h7)
               begin
                  rx_byte <= {rx_shift[6:0], mosi_sync[1]};
                  byte_done <= 1'b1;
                  bit_cnt <= 4'h0;
               end
            end
            else if (slave_fall && bit_cnt != 4'h0)
            begin
               o_pins.miso <= tx_shift[7];
               tx_shift <= {tx_shift[6:0], 1'b0};
            end
            else if (bit_cnt == 4'h0)
               o_pins.miso <= !tx_empty && tx_q[7]; // RULE_16
         end
      end
   end

   // interrupt source
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
         o_irq <= 1'b0;
      else if (cfg_one[`SMS_BIT_IRQ_SEL])
         o_irq <= port_en && tx_empty && !tx_full; // RULE_03
      else
         o_irq <= port_en && rx_full; // RULE_03
   end
endmodule

// file: sms_map.svh
// register map, field positions, reset values and timing counts
`ifndef SMS_MAP_SVH
`define SMS_MAP_SVH
`define SMS_ADDR_TX 8'h9A
`define SMS_ADDR_RX 8'h9B
`define SMS_ADDR_CFG1 8'hE8
`define SMS_ADDR_CFG2 8'hE9
`define SMS_CFG1_RST 8'h10
`define SMS_CFG2_RST 8'h00
`define SMS_RX_RST 8'h00
`define SMS_BIT_IRQ_SEL 5
`define SMS_BIT_AUTO_SS 4
`define SMS_BIT_SS_IN_EN 3
`define SMS_BIT_RX_REPLACE 2
`define SMS_BIT_CONT 7
`define SMS_BIT_PORT_EN 6
`define SMS_BIT_MASTER 4
`define SMS_CFG1_MASK 8'h3F
`define SMS_CFG2_MASK 8'hD0
`define SMS_STALL_NS 400
`define SMS_CLK_NS 50
`define SMS_STALL_CYC ((`SMS_STALL_NS + `SMS_CLK_NS - 1) / `SMS_CLK_NS)
`endif

// file: sms_pkg.sv
// types shared by the spi port
package sms_pkg;
   typedef struct packed {
      logic sclk;
      logic mosi;
      logic mosi_oe;
      logic miso;
      logic miso_oe;
      logic ss;
      logic ss_oe;
   } sms_pins_t;
   typedef enum logic [3:0] {
      SMS_IDLE = 4'b0001,
      SMS_SHIFT = 4'b0010,
      SMS_DONE = 4'b0100,
      SMS_STALL = 4'b1000
   } sms_state_t;
endpackage

// file: sms_fifo.sv
// byte fifo built from flip-flops
module sms_fifo #(
   parameter int DEPTH = 2
)(
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_push,
   input wire logic [7:0] i_data,
   input wire logic i_pop,
   output logic [7:0] o_data,
   output logic o_empty,
   output logic o_full
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH != 2 && DEPTH != 4 && DEPTH != 8)
   begin : g_depth_check
      $error("fifo depth must be 2, 4 or 8");
   end
   logic [7:0] mem [DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   logic do_push;
   logic do_pop;
   assign do_pop = i_pop && !o_empty;
   assign do_push = i_push && (!o_full || do_pop);
   assign o_data = mem[rd_ptr[AW-1:0]];
   assign o_empty = (wr_ptr == rd_ptr);
   assign o_full = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end
      else
      begin
         if (do_push)
            wr_ptr <= wr_ptr + 1'b1;
         if (do_pop)
            rd_ptr <= rd_ptr + 1'b1;
      end
   end
   always_ff @(posedge i_clock)
   begin
      if (do_push)
         mem[wr_ptr[AW-1:0]] <= i_data;
   end
endmodule

// file: sms_chk.sv
// assertions on the spi port pins and register reads
`include "sms_map.svh"
module sms_chk #(
   parameter int STALL_CYCLES = 8
)(
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic [7:0] i_addr,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] i_wdata,
   input wire logic [7:0] o_rdata,
   input wire logic o_irq,
   input wire sms_pkg::sms_pins_t o_pins
);
   logic [7:0] c1;
   logic [7:0] c2;
   logic [5:0] hi;
   logic [7:0] sh;
   wire en = c2[`SMS_BIT_PORT_EN];
   wire act = en && c2[`SMS_BIT_MASTER];
   wire man = act && !c1[`SMS_BIT_AUTO_SS];
   wire stl = act && !c2[`SMS_BIT_CONT] && c1[`SMS_BIT_AUTO_SS];
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);
   // shadow of the configuration registers
   always_ff @(posedge i_clock or negedge i_rst_n)
      if (!i_rst_n)
      begin
         c1 <= `SMS_CFG1_RST;
         c2 <= `SMS_CFG2_RST;
      end
      else if (i_wr && i_addr == `SMS_ADDR_CFG1)
         c1 <= i_wdata & `SMS_CFG1_MASK;
      else if (i_wr && i_addr == `SMS_ADDR_CFG2)
         c2 <= i_wdata & `SMS_CFG2_MASK;
   // cycles with sclk high and with select high
   always_ff @(posedge i_clock or negedge i_rst_n)
      if (!i_rst_n)
      begin
         hi <= 6'h00;
         sh <= 8'h00;
      end
      else
      begin
         hi <= o_pins.sclk ? hi + 6'h01 : 6'h00;
         sh <= !o_pins.ss ? 8'h00 : sh + {7'h00, sh != 8'hFF};
      end
   a_idle_when_off: assert property (!en && !$past(en) |-> o_pins.ss && !o_pins.sclk && !o_irq)
      else $error("port active while off");
   a_manual_select_low: assert property (man && $past(man) |-> !o_pins.ss)
      else $error("select not held low");
   a_sclk_half_period: assert property ($fell(o_pins.sclk) && act |-> hi == (6'h04 << c1[1:0]))
      else $error("sclk rate wrong");
   a_stall_gap: assert property ($fell(o_pins.ss) && stl |-> sh >= STALL_CYCLES)
      else $error("stall too short");
   a_sclk_in_frame: assert property ($rose(o_pins.sclk) |-> !o_pins.ss)
      else $error("sclk outside frame");
   a_cfg_one_read: assert property (i_rd && i_addr == `SMS_ADDR_CFG1 |=> o_rdata == $past(c1))
      else $error("cfg one readback");
   a_cfg_two_read: assert property (i_rd && i_addr == `SMS_ADDR_CFG2 |=> o_rdata == $past(c2))
      else $error("cfg two readback");
   a_rdata_holds: assert property (!i_rd |=> $stable(o_rdata))
      else $error("read data moved");
   a_slave_no_drive: assert property (en && !c2[`SMS_BIT_MASTER] && $past(c2) == c2 |->
      !o_pins.mosi_oe && !o_pins.ss_oe && !o_pins.sclk)
      else $error("slave drives master pins");
endmodule
bind sms_port sms_chk #(.STALL_CYCLES(STALL_CYCLES)) u_chk (.i_clock(i_clock), .i_rst_n(i_rst_n),
   .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata),
   .o_irq(o_irq), .o_pins(o_pins));

// file: sms_peer.sv
// behavioural spi slave facing the port in master mode
module sms_peer (
   input wire logic i_sclk,
   input wire logic i_ss_n,
   input wire logic i_mosi,
   input wire logic [7:0] i_reply,
   output logic o_miso,
   output logic [7:0] o_last,
   output int o_count
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] sh;
   int n;
   initial
   begin
      o_miso = 1'b0;
      o_last = 8'h00;
      o_count = 0;
   end
   // load the reply on select, msb first
   always @(negedge i_ss_n)
   begin
      sh = i_reply;
      n = 0;
      o_miso = sh[7];
   end
   always @(posedge i_sclk)
      if (!i_ss_n)
      begin
         sh = {sh[6:0], i_mosi};
         n++;
         if (n == 8)
         begin
            o_last = sh;
            o_count++;
            n = 0;
            sh = i_reply;
         end
      end
   always @(negedge i_sclk)
      if (!i_ss_n)
         o_miso = sh[7];
   // released line shows the inverse of its last level
   always @(posedge i_ss_n)
      o_miso = ~o_miso;
endmodule

// file: tb_top.sv
// self-checking bench for the spi port in master and slave mode
`include "sms_map.svh"
`define CHK(x, y) begin n_tests++; if ((x) !== (y)) begin failures++; \
   $display("MISMATCH %0t %h %h", $time, x, y); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_clock, i_rst_n, i_wr, i_rd, rd_d, i_sclk, i_mosi, i_ss_n, miso, o_irq;
   logic [7:0] i_addr, i_wdata, o_rdata, reply, last, a, e, rp[3];
   logic [7:0] exq[$];
   sms_pkg::sms_pins_t o_pins;
   int failures = 0, n_tests = 0, cnt, seed = 32'hf3da, k, m;
   sms_port u_dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wr(i_wr),
      .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_irq(o_irq), .i_sclk(i_sclk),
      .i_mosi(i_mosi), .i_miso(miso), .i_ss_n(i_ss_n), .o_pins(o_pins));
   sms_peer u_peer (.i_sclk(o_pins.sclk), .i_ss_n(o_pins.ss), .i_mosi(o_pins.mosi),
      .i_reply(reply), .o_miso(miso), .o_last(last), .o_count(cnt));
   initial
   begin
      i_clock = 1'b0;
      forever #25 i_clock = ~i_clock;
   end
   task test_done();
      $display("comparisons %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task wr(input logic [7:0] ad, input logic [7:0] d);
      i_addr = ad;
      i_wdata = d;
      i_wr = 1'b1;
      @(negedge i_clock);
      i_wr = 1'b0;
      @(negedge i_clock);
   endtask
   task rd(input logic [7:0] ad, input logic [7:0] x);
      exq.push_back(x);
      i_addr = ad;
      i_rd = 1'b1;
      @(negedge i_clock);
      i_rd = 1'b0;
      @(negedge i_clock);
   endtask
   task wss(input logic v);
      int j;
      j = 0;
      while (o_pins.ss !== v && j < 3000)
      begin
         @(negedge i_clock);
         j++;
      end
      if (j == 3000)
         failures++;
   endtask
   // one frame on the wire, then what the far side got
   task fin(input logic [7:0] t);
      wss(1'b0);
      wss(1'b1);
      repeat (3) @(negedge i_clock);
      `CHK(last, t)
   endtask
   // bench as master toward the port in slave mode, msb first
   task sxfer(input logic [7:0] d, input logic [7:0] t);
      logic [7:0] r;
      r = 8'h00;
      i_ss_n = 1'b0;
      repeat (8) @(negedge i_clock);
      `CHK(o_pins.miso_oe, 1'b1)
      for (int j = 0; j < 8; j++)
      begin
         i_mosi = d[7 - j];
         repeat (8) @(negedge i_clock);
         r = {r[6:0], o_pins.miso};
         i_sclk = 1'b1;
         repeat (8) @(negedge i_clock);
         i_sclk = 1'b0;
      end
      repeat (8) @(negedge i_clock);
      i_ss_n = 1'b1;
      repeat (4) @(negedge i_clock);
      `CHK(r, t)
   endtask
   always @(posedge i_clock)
      rd_d <= i_rd;
   always @(negedge i_clock)
      if (rd_d)
      begin
         e = exq.pop_front();
         `CHK(o_rdata, e)
      end
   initial
   begin
      repeat (20000) @(posedge i_clock);
      failures++;
      test_done();
   end
   initial
   begin
      {i_rst_n, i_wr, i_rd, i_sclk, i_mosi} = 5'h00;
      i_ss_n = 1'b1;
      i_addr = 8'h00;
      i_wdata = 8'h00;
      reply = 8'h00;
      repeat (20) @(negedge i_clock);
      i_rst_n = 1'b1;
      rd(`SMS_ADDR_CFG1, `SMS_CFG1_RST);
      rd(`SMS_ADDR_CFG2, `SMS_CFG2_RST);
      rd(`SMS_ADDR_RX, `SMS_RX_RST);
      rd(8'h55, 8'h00);
      a = $random(seed);
      wr(`SMS_ADDR_CFG1, a);
      rd(`SMS_ADDR_CFG1, a & `SMS_CFG1_MASK);
      wr(`SMS_ADDR_CFG1, 8'h10);
      reply = $random(seed);
      a = $random(seed);
      wr(`SMS_ADDR_TX, a);
      repeat (100) @(negedge i_clock);
      `CHK(cnt, 0)
      wr(`SMS_ADDR_CFG2, 8'h50);
      fin(a);
      rd(`SMS_ADDR_RX, reply);
      for (k = 0; k < 4; k++)
      begin
         wr(`SMS_ADDR_CFG1, 8'h10 | k[7:0]);
         reply = $random(seed);
         a = $random(seed);
         wr(`SMS_ADDR_TX, a);
         fin(a);
         rd(`SMS_ADDR_RX, reply);
      end
      wr(`SMS_ADDR_CFG1, 8'h30);
      `CHK(o_irq, 1'b1)
      for (m = 0; m < 2; m++)
      begin
         wr(`SMS_ADDR_CFG1, m ? 8'h14 : 8'h10);
         for (k = 0; k < 3; k++)
         begin
            `CHK(o_irq, k == 2)
            rp[k] = $random(seed);
            reply = rp[k];
            a = $random(seed);
            wr(`SMS_ADDR_TX, a);
            fin(a);
         end
         rd(`SMS_ADDR_RX, rp[m]);
         rd(`SMS_ADDR_RX, rp[m + 1]);
      end
      wr(`SMS_ADDR_CFG2, 8'hD0);
      reply = $random(seed);
      k = cnt;
      wr(`SMS_ADDR_TX, rp[0]);
      wr(`SMS_ADDR_TX, a);
      fin(a);
      `CHK(cnt, k + 2)
      rd(`SMS_ADDR_RX, reply);
      rd(`SMS_ADDR_RX, reply);
      wr(`SMS_ADDR_CFG2, 8'h50);
      wr(`SMS_ADDR_CFG1, 8'h00);
      @(negedge i_clock);
      `CHK(o_pins.ss, 1'b0)
      wr(`SMS_ADDR_CFG2, 8'h40);
      wr(`SMS_ADDR_CFG1, 8'h08);
      `CHK(o_pins.miso_oe, 1'b0)
      a = $random(seed);
      reply = $random(seed);
      wr(`SMS_ADDR_TX, reply);
      sxfer(a, reply);
      rd(`SMS_ADDR_RX, a);
      test_done();
   end
endmodule
